// ### pkg/adm_pkg.sv
// ---------------------------------------------------------------
// addressing mode decoder constants
// ---------------------------------------------------------------
package adm_pkg;

   // seventeen modes in seven families
   typedef enum logic [4:0] {
      M_INH, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
      M_IND_S, M_IND_L, M_IDXIND_S, M_IDXIND_L, M_REL_D, M_REL_I,
      M_BIT_D, M_BIT_I, M_BITREL_D, M_BITREL_I
   } adm_mode_e;

   // inherent operations with a side effect
   typedef enum logic [1:0] {
      INH_NONE, INH_MASK, INH_UNMASK, INH_SLEEP
   } adm_inh_e;

   localparam logic [4:0] NUM_MODES = 5'h11;
   localparam logic [2:0] NUM_FAMILIES = 3'h7;
   localparam logic [2:0] OPC_LEN = 3'h1;
   localparam logic [15:0] ADDR_STEP = 16'h0001;
   localparam logic [7:0] PAGE0 = 8'h00;
   localparam logic [15:0] IDX_S_MAX = 16'h01fe;
   localparam logic [1:0] OPB_0 = 2'h0;
   localparam logic [1:0] OPB_1 = 2'h1;
   localparam logic [1:0] OPB_2 = 2'h2;
   localparam logic [1:0] IMASK_ALL = 2'h3;
   localparam logic [1:0] IMASK_NONE = 2'h0;
   localparam logic [1:0] IMASK_RST = 2'h3;

   // bytes following the opcode
   function automatic logic [1:0] opnd_bytes(adm_mode_e m);
      case (m)
         M_INH, M_IDX_0: opnd_bytes = OPB_0;
         M_DIR_L, M_IDX_L, M_BITREL_D, M_BITREL_I: opnd_bytes = OPB_2;
         default: opnd_bytes = OPB_1;
      endcase
   endfunction

   // bytes of pointer read from page zero
   function automatic logic [1:0] ptr_bytes(adm_mode_e m);
      case (m)
         M_IND_S, M_IDXIND_S, M_REL_I, M_BIT_I, M_BITREL_I: ptr_bytes = OPB_1;
         M_IND_L, M_IDXIND_L: ptr_bytes = OPB_2;
         default: ptr_bytes = OPB_0;
      endcase
   endfunction

   // long variants reach the whole space
   function automatic logic is_long(adm_mode_e m);
      is_long = (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L) || (m == M_IDXIND_L);
   endfunction

endpackage

// ### pkg/adm_ea_if.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// operands in, effective address out
// ---------------------------------------------------------------
interface adm_ea_if;
   adm_pkg::adm_mode_e mode;
   logic [15:0] opnd;
   logic [15:0] ptr;
   logic [7:0] idx;
   logic [15:0] next_pc;
   logic [15:0] ea;
   logic [15:0] target;
   modport calc (input mode, opnd, ptr, idx, next_pc, output ea, target);
   modport ctrl (output mode, opnd, ptr, idx, next_pc, input ea, target);
endinterface

// ### rtl/adm_ea_calc.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// effective address and branch target
// ---------------------------------------------------------------
module adm_ea_calc (
   // operand and result bundle
   adm_ea_if.calc ea
);
   logic [8:0] sum_s;
   logic [15:0] sum_l;
   logic [7:0] rel_off;

   always_comb begin
      sum_s = {1'b0, (ea.mode == adm_pkg::M_IDXIND_S) ? ea.ptr[7:0] : ea.opnd[7:0]}
         + {1'b0, ea.idx};
      sum_l = ((ea.mode == adm_pkg::M_IDXIND_L) ? ea.ptr : ea.opnd)
         + {adm_pkg::PAGE0, ea.idx};
      // signed offset, from memory in the indirect form
      rel_off = (ea.mode == adm_pkg::M_REL_I) ? ea.ptr[7:0] : ea.opnd[7:0];
      ea.target = ea.next_pc + {{8{rel_off[7]}}, rel_off};
      unique case (ea.mode)
         adm_pkg::M_DIR_S, adm_pkg::M_BIT_D: ea.ea = {adm_pkg::PAGE0, ea.opnd[7:0]};
         adm_pkg::M_DIR_L: ea.ea = ea.opnd;
         adm_pkg::M_IDX_0: ea.ea = {adm_pkg::PAGE0, ea.idx};
         adm_pkg::M_IDX_S, adm_pkg::M_IDXIND_S: ea.ea = {7'h00, sum_s};
         adm_pkg::M_IDX_L, adm_pkg::M_IDXIND_L: ea.ea = sum_l;
         adm_pkg::M_IND_S, adm_pkg::M_BIT_I, adm_pkg::M_BITREL_I:
            ea.ea = {adm_pkg::PAGE0, ea.ptr[7:0]};
         adm_pkg::M_IND_L: ea.ea = ea.ptr;
         adm_pkg::M_BITREL_D: ea.ea = {adm_pkg::PAGE0, ea.opnd[15:8]};
         default: ea.ea = 16'h0000;
      endcase
   end

endmodule // adm_ea_calc

// ### rtl/adm_decoder.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Overview of operation
// - inherent instructions are one byte, no operand fetched
// - immediate is opcode plus one byte used as the value
// - short direct fetches one address byte, page zero only
// - long direct fetches a two-byte address, whole 64k space
// - indexed address is unsigned sum of X or Y and offset
// - indexed without offset fetches nothing, index is the address
// - short indexed fetches one offset byte, sum reaches 1fe
// - long indexed fetches a two-byte offset, whole space
// - indirect reads pointer address, fetches pointer, then operand address
// - short indirect uses byte pointer, page zero, one byte after opcode
// - long indirect uses word pointer, whole space, one byte after opcode
// - short variants reach page zero, the indexed ones up to 1fe; short direct and indexed need fewer bytes
// - read-modify-write instructions allow only short modes
// - long variants cover 64k, direct and indexed at the cost of an extra byte, indirect ones through a word pointer
// - seventeen modes in seven families are decoded
// - mask instruction raises interrupt mask to level 3
// - unmask instruction lowers interrupt mask to level 0
// ---------------------------------------------------------------
module adm_decoder (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // decode request
   input wire logic DEC_VALID,
   output logic DEC_READY,
   input wire logic [4:0] DEC_MODE,
   input wire logic DEC_PREFIX,
   input wire logic DEC_USE_Y,
   input wire logic DEC_RMW,
   input wire logic [1:0] DEC_INH_OP,
   input wire logic [15:0] DEC_PC,
   input wire logic [7:0] INDEX_X,
   input wire logic [7:0] INDEX_Y,
   // program and data memory
   output logic MEM_REQ,
   output logic [15:0] MEM_ADDR,
   input wire logic MEM_ACK,
   input wire logic [7:0] MEM_RDATA,
   // decode result
   output logic RES_VALID,
   output logic [2:0] RES_LEN,
   output logic [15:0] RES_EA,
   output logic [15:0] RES_TARGET,
   output logic [7:0] RES_IMM,
   output logic RES_MODE_ERR,
   output logic [1:0] IMASK_LEVEL,
   output logic SLEEP_REQ
);

   typedef enum logic [1:0] {S_IDLE, S_OPND, S_PTR, S_DONE} adm_state_e;

   adm_state_e state_q, state_d;
   adm_pkg::adm_mode_e mode_q, mode_d, mode_in;
   adm_pkg::adm_inh_e inh_q, inh_d;
   logic pfx_q, pfx_d, err_q, err_d, mode_bad;
   logic [1:0] cnt_q, cnt_d;
   logic [7:0] idx_q, idx_d;
   logic [15:0] addr_q, addr_d, opnd_q, opnd_d, ptr_q, ptr_d, npc_q, npc_d;
   logic [2:0] len_q, len_d;
   logic res_valid_q, res_valid_d, res_err_q, res_err_d, sleep_q, sleep_d;
   logic [2:0] res_len_q, res_len_d;
   logic [15:0] res_ea_q, res_ea_d, res_tgt_q, res_tgt_d;
   logic [7:0] res_imm_q, res_imm_d;
   logic [1:0] imask_q, imask_d;

   adm_ea_if eif ();

   // ---------------------------------------------------------------
   // address arithmetic
   // ---------------------------------------------------------------
   assign eif.mode = mode_q;
   assign eif.opnd = opnd_q;
   assign eif.ptr = ptr_q;
   assign eif.idx = idx_q;
   assign eif.next_pc = npc_q;

   adm_ea_calc u_ea (
      .ea(eif)
   );

   // ---------------------------------------------------------------
   // fetch sequencer
   // ---------------------------------------------------------------
   // codes past the seventeen modes are refused
   assign mode_bad = DEC_MODE >= adm_pkg::NUM_MODES;
   assign mode_in = mode_bad ? adm_pkg::M_INH : adm_pkg::adm_mode_e'(DEC_MODE);

   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      inh_d = inh_q;
      pfx_d = pfx_q;
      err_d = err_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      addr_d = addr_q;
      opnd_d = opnd_q;
      ptr_d = ptr_q;
      npc_d = npc_q;
      len_d = len_q;
      res_valid_d = 1'b0;
      res_len_d = res_len_q;
      res_ea_d = res_ea_q;
      res_tgt_d = res_tgt_q;
      res_imm_d = res_imm_q;
      res_err_d = res_err_q;
      imask_d = imask_q;
      sleep_d = 1'b0;
      unique case (state_q)
         S_IDLE: if (DEC_VALID) begin
            mode_d = mode_in;
            pfx_d = DEC_PREFIX;
            idx_d = DEC_USE_Y ? INDEX_Y : INDEX_X;
            err_d = mode_bad | (DEC_RMW & adm_pkg::is_long(mode_in));
            inh_d = (mode_in == adm_pkg::M_INH) ? adm_pkg::adm_inh_e'(DEC_INH_OP)
               : adm_pkg::INH_NONE;
            len_d = adm_pkg::OPC_LEN + {2'h0, DEC_PREFIX}
               + {1'b0, adm_pkg::opnd_bytes(mode_in)};
            npc_d = DEC_PC + {13'h0000, len_d};
            addr_d = DEC_PC + {13'h0000, adm_pkg::OPC_LEN} + {15'h0000, DEC_PREFIX};
            opnd_d = 16'h0000;
            ptr_d = 16'h0000;
            cnt_d = adm_pkg::opnd_bytes(mode_in);
            if (err_d || adm_pkg::opnd_bytes(mode_in) == adm_pkg::OPB_0) begin
               state_d = S_DONE;
            end else begin
               state_d = S_OPND;
            end
         end
         S_OPND: if (MEM_ACK) begin
            // high byte of a word comes first
            opnd_d = {opnd_q[7:0], MEM_RDATA};
            addr_d = addr_q + adm_pkg::ADDR_STEP;
            cnt_d = cnt_q - adm_pkg::OPB_1;
            if (cnt_q == adm_pkg::OPB_1) begin
               if (adm_pkg::ptr_bytes(mode_q) != adm_pkg::OPB_0) begin
                  // pointer sits at the fetched page-zero address
                  state_d = S_PTR;
                  cnt_d = adm_pkg::ptr_bytes(mode_q);
                  addr_d = {adm_pkg::PAGE0,
                     (mode_q == adm_pkg::M_BITREL_I) ? opnd_q[7:0] : MEM_RDATA};
               end else begin
                  state_d = S_DONE;
               end
            end
         end
         S_PTR: if (MEM_ACK) begin
            // word pointer read high byte first
            ptr_d = {ptr_q[7:0], MEM_RDATA};
            addr_d = addr_q + adm_pkg::ADDR_STEP;
            cnt_d = cnt_q - adm_pkg::OPB_1;
            if (cnt_q == adm_pkg::OPB_1) begin
               state_d = S_DONE;
            end
         end
         S_DONE: begin
            state_d = S_IDLE;
            res_valid_d = 1'b1;
            res_len_d = len_q;
            res_ea_d = eif.ea;
            res_tgt_d = eif.target;
            // second byte is the value itself
            res_imm_d = opnd_q[7:0];
            res_err_d = err_q;
            if (!err_q && inh_q == adm_pkg::INH_MASK) begin
               imask_d = adm_pkg::IMASK_ALL;
            end
            if (!err_q && inh_q == adm_pkg::INH_UNMASK) begin
               imask_d = adm_pkg::IMASK_NONE;
            end
            sleep_d = !err_q && inh_q == adm_pkg::INH_SLEEP;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         state_q <= S_IDLE;
         mode_q <= adm_pkg::M_INH;
         inh_q <= adm_pkg::INH_NONE;
         pfx_q <= 1'b0;
         err_q <= 1'b0;
         cnt_q <= adm_pkg::OPB_0;
         idx_q <= 8'h00;
         addr_q <= 16'h0000;
         opnd_q <= 16'h0000;
         ptr_q <= 16'h0000;
         npc_q <= 16'h0000;
         len_q <= adm_pkg::OPC_LEN;
         res_valid_q <= 1'b0;
         res_len_q <= adm_pkg::OPC_LEN;
         res_ea_q <= 16'h0000;
         res_tgt_q <= 16'h0000;
         res_imm_q <= 8'h00;
         res_err_q <= 1'b0;
         imask_q <= adm_pkg::IMASK_RST;
         sleep_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         inh_q <= inh_d;
         pfx_q <= pfx_d;
         err_q <= err_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         addr_q <= addr_d;
         opnd_q <= opnd_d;
         ptr_q <= ptr_d;
         npc_q <= npc_d;
         len_q <= len_d;
         res_valid_q <= res_valid_d;
         res_len_q <= res_len_d;
         res_ea_q <= res_ea_d;
         res_tgt_q <= res_tgt_d;
         res_imm_q <= res_imm_d;
         res_err_q <= res_err_d;
         imask_q <= imask_d;
         sleep_q <= sleep_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign DEC_READY = state_q == S_IDLE;
   // memory held until acknowledged, no timeout
   assign MEM_REQ = state_q == S_OPND || state_q == S_PTR;
   assign MEM_ADDR = addr_q;
   assign RES_VALID = res_valid_q;
   assign RES_LEN = res_len_q;
   assign RES_EA = res_ea_q;
   assign RES_TARGET = res_tgt_q;
   assign RES_IMM = res_imm_q;
   assign RES_MODE_ERR = res_err_q;
   assign IMASK_LEVEL = imask_q;
   assign SLEEP_REQ = sleep_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_INH_NO_FETCH: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (DEC_READY && DEC_VALID && DEC_MODE == 5'h00)
      |=> !MEM_REQ ##1 (RES_VALID && RES_LEN == adm_pkg::OPC_LEN + {2'h0, pfx_q}))
      else $error("inherent op fetched or wrong length");

   AST_IMM_VALUE: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (MEM_REQ && MEM_ACK && mode_q == adm_pkg::M_IMM)
      |-> ##2 (RES_VALID && RES_IMM == $past(MEM_RDATA, 2)
         && RES_LEN == adm_pkg::OPC_LEN + {1'b0, adm_pkg::OPB_1} + {2'h0, pfx_q}))
      else $error("immediate value or length wrong");

   AST_DIR_SHORT_PAGE0: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (RES_VALID && mode_q == adm_pkg::M_DIR_S) |-> RES_EA == {8'h00, opnd_q[7:0]})
      else $error("short direct left page zero");

   AST_LONG_TWO_BYTES: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (MEM_REQ && MEM_ACK && mode_q == adm_pkg::M_DIR_L)
      |=> (MEM_REQ == (MEM_ADDR != npc_q)))
      else $error("long direct fetch count wrong");

   AST_IDX_NO_OFFSET: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (RES_VALID && mode_q == adm_pkg::M_IDX_0) |-> RES_EA == {8'h00, idx_q})
      else $error("no-offset indexed address wrong");

   AST_IDX_SHORT_SUM: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (RES_VALID && mode_q == adm_pkg::M_IDX_S)
      |-> (RES_EA <= adm_pkg::IDX_S_MAX && RES_EA == {8'h00, opnd_q[7:0]} + {8'h00, idx_q}))
      else $error("short indexed sum wrong");

   AST_PTR_PAGE0: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (MEM_REQ && state_q == S_PTR) |-> MEM_ADDR[15:9] == 7'h00)
      else $error("pointer read outside page zero");

   AST_IND_LONG_EA: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (RES_VALID && mode_q == adm_pkg::M_IND_L) |-> RES_EA == ptr_q)
      else $error("long indirect address differs from pointer");

   AST_RMW_LONG_REFUSED: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (DEC_READY && DEC_VALID && DEC_RMW && DEC_MODE == 5'h06)
      |=> !MEM_REQ ##1 (RES_VALID && RES_MODE_ERR))
      else $error("long mode accepted for read-modify-write");

   AST_MASK_LEVEL3: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (DEC_READY && DEC_VALID && DEC_MODE == 5'h00 && DEC_INH_OP == 2'h1)
      |-> ##2 IMASK_LEVEL == 2'h3)
      else $error("mask did not reach level 3");

   AST_UNMASK_LEVEL0: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      (DEC_READY && DEC_VALID && DEC_MODE == 5'h00 && DEC_INH_OP == 2'h2)
      |-> ##2 IMASK_LEVEL == 2'h0)
      else $error("unmask did not reach level 0");

   AST_LENGTH: assert property (
      @(posedge REF_CLK) disable iff (RESET)
      RES_VALID |-> RES_LEN == adm_pkg::OPC_LEN + {2'h0, pfx_q}
         + {1'b0, adm_pkg::opnd_bytes(mode_q)})
      else $error("instruction length wrong");

endmodule // adm_decoder

// ### testbench/adm_mem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// program and data memory, byte wide, stretchable wait
// ---------------------------------------------------------------
module adm_mem_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // read port
   input wire logic req,
   input wire logic [15:0] addr,
   output logic ack,
   output logic [7:0] rdata,
   // wait cycles before each answer
   input wire logic [1:0] wait_cyc
);
   logic [1:0] cnt_q;
   logic [7:0] last_q;

   // contents follow the address so the bench can predict them
   assign ack = req && (cnt_q == wait_cyc);
   // idle data is the inverse of the last byte, never a stale copy
   assign rdata = ack ? (addr[7:0] ^ addr[15:8] ^ 8'h3c) : ~last_q;

   always_ff @(posedge clk) begin
      if (rst || !req || ack) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
      if (rst) begin
         last_q <= 8'h00;
      end else if (ack) begin
         last_q <= rdata;
      end
   end
endmodule // adm_mem_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk, rst, dv, drdy, pre, use_y, rmw, mreq, mack, rv, merr, sleep;
   logic [4:0] mode;
   logic [1:0] inh, imask, wcyc;
   logic [15:0] pc, maddr, ea, tgt;
   logic [7:0] ix, iy, mrd, imm;
   logic [2:0] len;
   int mismatches, check_count, rd_cnt, nrd;

   adm_decoder u_dut (.REF_CLK(clk), .RESET(rst), .DEC_VALID(dv), .DEC_READY(drdy),
      .DEC_MODE(mode), .DEC_PREFIX(pre), .DEC_USE_Y(use_y), .DEC_RMW(rmw),
      .DEC_INH_OP(inh), .DEC_PC(pc), .INDEX_X(ix), .INDEX_Y(iy), .MEM_REQ(mreq),
      .MEM_ADDR(maddr), .MEM_ACK(mack), .MEM_RDATA(mrd), .RES_VALID(rv), .RES_LEN(len),
      .RES_EA(ea), .RES_TARGET(tgt), .RES_IMM(imm), .RES_MODE_ERR(merr),
      .IMASK_LEVEL(imask), .SLEEP_REQ(sleep));

   adm_mem_model u_mem (.clk(clk), .rst(rst), .req(mreq), .addr(maddr), .ack(mack),
      .rdata(mrd), .wait_cyc(wcyc));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      if (mreq === 1'b1 && mack === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] mb(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   // one request, held for one cycle only, then a bounded wait of 40 cycles for the result
   task automatic dec(input logic [4:0] md, input logic p, input logic y, input logic r,
                      input logic [1:0] io, input logic [15:0] a);
      int n0;
      n0 = rd_cnt;
      @(posedge clk);
      dv <= 1'b1;
      mode <= md;
      pre <= p;
      use_y <= y;
      rmw <= r;
      inh <= io;
      pc <= a;
      @(posedge clk);
      dv <= 1'b0;
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         #1;
         if (rv === 1'b1) break;
      end
      if (rv !== 1'b1) begin
         mismatches++;
         $display("MISMATCH result valid expected 1 seen %b", rv);
         end_sim;
      end
      nrd = rd_cnt - n0;
      chk("ready", 16'h0001, {15'h0000, drdy});
   endtask

   task automatic run_mode(input logic [4:0] md, input logic p, input logic y,
                           input logic [15:0] a);
      logic [7:0] o1, o2, idx, off;
      logic [15:0] e, pa;
      int nops, nptr;
      logic dot;
      idx = y ? iy : ix;
      o1 = mb(a + 16'(p) + 16'h0001);
      o2 = mb(a + 16'(p) + 16'h0002);
      pa = {8'h00, o1};
      nops = 1;
      nptr = 0;
      e = 16'h0000;
      dot = 1'b0;
      off = o1;
      case (md)
         5'h00: nops = 0;
         5'h02, 5'h0d: e = pa;
         5'h03: begin nops = 2; e = {o1, o2}; end
         5'h04: begin nops = 0; e = {8'h00, idx}; end
         5'h05: e = pa + 16'(idx);
         5'h06: begin nops = 2; e = {o1, o2} + 16'(idx); end
         5'h07, 5'h0e: begin nptr = 1; e = {8'h00, mb(pa)}; end
         5'h08: begin nptr = 2; e = {mb(pa), mb(pa + 16'h0001)}; end
         5'h09: begin nptr = 1; e = {8'h00, mb(pa)} + 16'(idx); end
         5'h0a: begin nptr = 2; e = {mb(pa), mb(pa + 16'h0001)} + 16'(idx); end
         5'h0b: dot = 1'b1;
         5'h0c: begin nptr = 1; dot = 1'b1; off = mb(pa); end
         5'h0f: begin nops = 2; e = pa; dot = 1'b1; off = o2; end
         5'h10: begin nops = 2; nptr = 1; e = {8'h00, mb(pa)}; dot = 1'b1; off = o2; end
         default: nops = 1;
      endcase
      dec(md, p, y, 1'b0, 2'h0, a);
      chk("length", 16'(1 + p + nops), {13'h0000, len});
      chk("address", e, ea);
      chk("reads", 16'(nops + nptr), 16'(nrd));
      chk("mode error", 16'h0000, {15'h0000, merr});
      if (md == 5'h01) chk("immediate", {8'h00, o1}, {8'h00, imm});
      if (dot) chk("target", a + 16'(1 + p + nops) + {{8{off[7]}}, off}, tgt);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_modes;
      @(posedge clk);
      ix <= 8'h37;
      iy <= 8'hc9;
      wcyc <= 2'h0;
      for (int i = 0; i < 17; i++) run_mode(5'(i), 1'b0, 1'b0, 16'h2000 + 16'(i * 17));
      wcyc <= 2'h2;
      for (int i = 0; i < 17; i++) run_mode(5'(i), 1'b1, 1'b1, 16'h8100 + 16'(i * 5));
      $display("test modes done");
   endtask

   // offset and pointer address of ff: index sum and pointer cross the page
   task automatic t_boundary;
      @(posedge clk);
      ix <= 8'hff;
      wcyc <= 2'h1;
      @(posedge clk);
      run_mode(5'h05, 1'b0, 1'b0, 16'h00c2);
      run_mode(5'h02, 1'b0, 1'b0, 16'h00c2);
      run_mode(5'h04, 1'b0, 1'b0, 16'h00c2);
      run_mode(5'h08, 1'b0, 1'b0, 16'h00c2);
      run_mode(5'h07, 1'b0, 1'b0, 16'h00c2);
      $display("test boundary done");
   endtask

   task automatic t_inherent;
      logic [1:0] ops [5] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h1};
      logic [1:0] lvl [5] = '{2'h3, 2'h0, 2'h0, 2'h0, 2'h3};
      for (int i = 0; i < 5; i++) begin
         dec(5'h00, 1'b0, 1'b0, 1'b0, ops[i], 16'h3000);
         chk("mask level", {14'h0000, lvl[i]}, {14'h0000, imask});
         chk("sleep", {15'h0000, ops[i] == 2'h3}, {15'h0000, sleep});
         chk("length", 16'h0001, {13'h0000, len});
         chk("reads", 16'h0000, 16'(nrd));
      end
      $display("test inherent done");
   endtask

   task automatic t_refuse;
      logic [4:0] md [6] = '{5'h03, 5'h06, 5'h08, 5'h0a, 5'h11, 5'h1f};
      for (int i = 0; i < 6; i++) begin
         dec(md[i], 1'b0, 1'b0, i < 4, 2'h0, 16'h4000);
         chk("mode error", 16'h0001, {15'h0000, merr});
         chk("reads", 16'h0000, 16'(nrd));
      end
      dec(5'h05, 1'b0, 1'b0, 1'b1, 2'h0, 16'h4000);
      chk("mode error", 16'h0000, {15'h0000, merr});
      $display("test refuse done");
   endtask

   initial begin
      {dv, pre, use_y, rmw} = 4'h0;
      mode = 5'h00;
      inh = 2'h0;
      pc = 16'h0000;
      ix = 8'h00;
      iy = 8'h00;
      wcyc = 2'h0;
      rd_cnt = 0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("reset mask level", 16'h0003, {14'h0000, imask});
      chk("reset length", 16'h0001, {13'h0000, len});
      t_modes;
      t_boundary;
      t_inherent;
      t_refuse;
      end_sim;
   end
endmodule // testbench
